// *** include/pwoc_consts.svh ***
`ifndef PWOC_CONSTS_SVH
`define PWOC_CONSTS_SVH

// Register byte offsets on the register bus
`define PWOC_OFS_OE_LOW 8'h00
`define PWOC_OFS_OE_HIGH 8'h04
`define PWOC_OFS_DIR_ONE 8'h08
`define PWOC_OFS_DIR_TWO 8'h0c
`define PWOC_OFS_LVL_ONE 8'h10
`define PWOC_OFS_LVL_TWO 8'h14
`define PWOC_OFS_SHARED_SERIAL_TIMER_CONTROL 8'h18
`define PWOC_OFS_POL_LOW 8'h1c
`define PWOC_OFS_POL_HIGH 8'h20
`define PWOC_OFS_COUNT 8'h24
`define PWOC_OFS_DUTY_BASE 8'h40
`define PWOC_OFS_DUTY_LAST 8'h7c

// Reset values
`define PWOC_RST_BYTE 8'h00

// Control register field positions
`define PWOC_BIT_CLK_GATE 3
`define PWOC_BIT_CLK_CHOICE 2
`define PWOC_BIT_SYNC_GATE 4
`define PWOC_LSB_TWO_WIRE 5
`define PWOC_MSB_TWO_WIRE 7
`define PWOC_LSB_BYTE_TMR 0
`define PWOC_MSB_BYTE_TMR 1

// Duty field layout and conversion timing
`define PWOC_DUTY_BASIC_LSB 4
`define PWOC_POS_LAST 4'hf

`endif

// *** include/pwoc_pkg.sv ***
package pwoc_pkg;

	typedef logic [7:0] pwoc_byte_type;

	// Pin mode chosen from direction and output-enable bits
	typedef enum logic [1:0] {
		PWOC_PIN_INPUT = 2'b00,
		PWOC_PIN_LEVEL = 2'b01,
		PWOC_PIN_WAVE = 2'b10
	} pwoc_pin_mode_type;

endpackage

// *** src/pwoc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pwoc_consts.svh"

// Function
// RL1 - Sixteen output-enable bits in two bytes pick waveform or port output per pin.
// RL2 - Port one direction governs pins 0-7, port two direction pins 8-15.
// RL3 - Direction bit clear keeps the pin an input regardless of output enable.
// RL4 - Direction set, enable clear drives the port level; gives full-scale output.
// RL5 - Direction and enable both set drive the waveform, duty 0 to 255/256.
// RL6 - Output-enable bytes clear on reset and during hardware standby.
// RL7 - Direction registers are 8-bit and write-only, one bit per pin.
// RL8 - Software sets direction bits of every pin it uses as pulse output.
// RL9 - Port level bits fix a pin: 1 when polarity clear, 0 when set.
// RL10 - Shared control register is 8-bit read-write and clears on reset.
// RL11 - Clock gate bit clear stops the counter whatever the select bit.
// RL12 - Gate set: select clear counts system clock, set counts half clock.
// RL13 - One counter step is the least pulse width; 256 steps per period.
// RL14 - A period holds sixteen basic pulses.
// RL15 - Control bits 1:0 are kept and passed to the byte timers.
// RL16 - Bit 4 goes to the interconnect unit, bits 7:5 to the two-wire unit.
// RL17 - Duty upper nibble sets basic width, lower nibble adds extra pulses.
// RL18 - Polarity bit clear drives directly, set inverts the pin.
// RL19 - Shared 8-bit counter steps per tick, wraps at 256, holds when stopped.
module pwoc_top #(
	parameter int CHANNELS = 16
) (
	input wire logic sys_clk_i, // System clock
	input wire logic reset_i, // Synchronous reset, high
	input wire logic standby_i, // Hardware standby level
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte selects
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	output logic [CHANNELS-1:0] pulse_out_pin_o, // Pin level
	output logic [CHANNELS-1:0] pulse_out_pin_oe_n_o, // Pin enable, low drives
	output logic [1:0] byte_timer_clock_sel_o, // To byte timers
	output logic interconnect_output_gate_o, // To interconnect unit
	output logic [2:0] two_wire_ctrl_o, // To two-wire unit
	output logic [7:0] shared_up_counter_o // Counter value
);

	// Bit-reverse of a nibble, used to spread extra pulses
	function automatic logic [3:0] rev4(input logic [3:0] v);
		rev4 = {v[0], v[1], v[2], v[3]};
	endfunction

	// Waveform level for one duty value at one counter value
	function automatic logic wave_bit(input pwoc_pkg::pwoc_byte_type duty,
			input logic [7:0] cnt);
		logic [3:0] basic;
		logic [3:0] extra;
		logic [3:0] pos;
		logic [3:0] next_idx;
		basic = duty[7:`PWOC_DUTY_BASIC_LSB];
		extra = duty[`PWOC_DUTY_BASIC_LSB-1:0];
		pos = cnt[3:0];
		next_idx = cnt[7:4] + 4'h1;
		// Extra step sits just before the next basic pulse rises
		wave_bit = (pos < basic) ||
			((pos == `PWOC_POS_LAST) && (rev4(~next_idx) < extra));
	endfunction

	pwoc_pkg::pwoc_byte_type oe_low_q;
	pwoc_pkg::pwoc_byte_type oe_high_q;
	pwoc_pkg::pwoc_byte_type dir_one_q;
	pwoc_pkg::pwoc_byte_type dir_two_q;
	pwoc_pkg::pwoc_byte_type lvl_one_q;
	pwoc_pkg::pwoc_byte_type lvl_two_q;
	pwoc_pkg::pwoc_byte_type shared_serial_timer_control_q;
	pwoc_pkg::pwoc_byte_type pol_low_q;
	pwoc_pkg::pwoc_byte_type pol_high_q;
	pwoc_pkg::pwoc_byte_type duty_q [CHANNELS];
	logic [7:0] count_q;
	logic half_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [CHANNELS-1:0] pin_q;
	logic [CHANNELS-1:0] oe_n_q;

	// Bus decode
	wire logic req = wb_cyc_i && wb_stb_i && !ack_q;
	wire logic wr = req && wb_we_i && wb_sel_i[0];
	wire pwoc_pkg::pwoc_byte_type wbyte = wb_dat_i[7:0];
	wire logic hit_oe_low = wb_adr_i == `PWOC_OFS_OE_LOW;
	wire logic hit_oe_high = wb_adr_i == `PWOC_OFS_OE_HIGH;
	wire logic hit_dir_one = wb_adr_i == `PWOC_OFS_DIR_ONE;
	wire logic hit_dir_two = wb_adr_i == `PWOC_OFS_DIR_TWO;
	wire logic hit_lvl_one = wb_adr_i == `PWOC_OFS_LVL_ONE;
	wire logic hit_lvl_two = wb_adr_i == `PWOC_OFS_LVL_TWO;
	wire logic hit_shared_serial_timer_control = wb_adr_i == `PWOC_OFS_SHARED_SERIAL_TIMER_CONTROL;
	wire logic hit_pol_low = wb_adr_i == `PWOC_OFS_POL_LOW;
	wire logic hit_pol_high = wb_adr_i == `PWOC_OFS_POL_HIGH;
	wire logic hit_count = wb_adr_i == `PWOC_OFS_COUNT;
	wire logic hit_duty = (wb_adr_i >= `PWOC_OFS_DUTY_BASE) &&
		(wb_adr_i <= `PWOC_OFS_DUTY_LAST) && (wb_adr_i[1:0] == 2'h0);
	wire logic [3:0] duty_idx = wb_adr_i[5:2];

	// Write strobes, one per register
	wire logic wr_oe_low = wr && hit_oe_low;
	wire logic wr_oe_high = wr && hit_oe_high;
	wire logic wr_dir_one = wr && hit_dir_one;
	wire logic wr_dir_two = wr && hit_dir_two;
	wire logic wr_lvl_one = wr && hit_lvl_one;
	wire logic wr_lvl_two = wr && hit_lvl_two;
	wire logic wr_shared_serial_timer_control = wr && hit_shared_serial_timer_control;
	wire logic wr_pol_low = wr && hit_pol_low;
	wire logic wr_pol_high = wr && hit_pol_high;
	wire logic wr_duty = wr && hit_duty;

	// Counter clock selection
	wire logic clk_gate = shared_serial_timer_control_q[`PWOC_BIT_CLK_GATE];
	wire logic clk_choice = shared_serial_timer_control_q[`PWOC_BIT_CLK_CHOICE];
	wire logic tick = clk_gate && (!clk_choice || half_q); // RL11 RL12

	// Pin controls gathered across both ports
	wire logic [CHANNELS-1:0] dir_all = {dir_two_q, dir_one_q}; // RL2
	wire logic [CHANNELS-1:0] oe_all = {oe_high_q, oe_low_q}; // RL1
	wire logic [CHANNELS-1:0] lvl_all = {lvl_two_q, lvl_one_q};
	wire logic [CHANNELS-1:0] pol_all = {pol_high_q, pol_low_q};

	// Read data selection; direction registers read as zero
	logic [7:0] rsel;
	always_comb begin
		rsel = 8'h00;
		if (hit_oe_low) rsel = oe_low_q;
		if (hit_oe_high) rsel = oe_high_q;
		if (hit_lvl_one) rsel = lvl_one_q;
		if (hit_lvl_two) rsel = lvl_two_q;
		if (hit_shared_serial_timer_control) rsel = shared_serial_timer_control_q; // RL10
		if (hit_pol_low) rsel = pol_low_q;
		if (hit_pol_high) rsel = pol_high_q;
		if (hit_count) rsel = count_q;
		if (hit_duty) rsel = duty_q[duty_idx];
	end

	// Waveform level of every channel before polarity
	logic [CHANNELS-1:0] wave_all;
	always_comb begin
		wave_all = '0;
		for (int n = 0; n < CHANNELS; n++) begin
			wave_all[n] = wave_bit(duty_q[n], count_q); // RL17
		end
	end

	// Per-pin mode and next pin level
	logic [CHANNELS-1:0] pin_d;
	logic [CHANNELS-1:0] oe_n_d;
	pwoc_pkg::pwoc_pin_mode_type mode;
	always_comb begin
		pin_d = '0;
		oe_n_d = '1;
		mode = pwoc_pkg::PWOC_PIN_INPUT;
		for (int n = 0; n < CHANNELS; n++) begin
			if (!dir_all[n]) begin
				mode = pwoc_pkg::PWOC_PIN_INPUT; // RL3
			end else if (!oe_all[n]) begin
				mode = pwoc_pkg::PWOC_PIN_LEVEL; // RL4
			end else begin
				mode = pwoc_pkg::PWOC_PIN_WAVE; // RL5
			end
			unique case (mode)
				pwoc_pkg::PWOC_PIN_INPUT: begin
					pin_d[n] = 1'b0;
					oe_n_d[n] = 1'b1;
				end
				pwoc_pkg::PWOC_PIN_LEVEL: begin
					pin_d[n] = lvl_all[n] ^ pol_all[n]; // RL9
					oe_n_d[n] = 1'b0;
				end
				default: begin
					pin_d[n] = wave_all[n] ^ pol_all[n]; // RL17 RL18
					oe_n_d[n] = 1'b0;
				end
			endcase
		end
	end

	// Acknowledge: one wait state, high for one cycle
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// Read data stands only in the acknowledge cycle
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= req ? {24'h00_0000, rsel} : 32'h0000_0000;
		end
	end

	// Low output-enable byte, cleared in standby
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || standby_i) begin
			oe_low_q <= `PWOC_RST_BYTE; // RL6
		end else if (wr_oe_low) begin
			oe_low_q <= wbyte; // RL1
		end
	end

	// High output-enable byte, cleared in standby
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || standby_i) begin
			oe_high_q <= `PWOC_RST_BYTE; // RL6
		end else if (wr_oe_high) begin
			oe_high_q <= wbyte; // RL1
		end
	end

	// Low polarity byte, cleared in standby
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || standby_i) begin
			pol_low_q <= `PWOC_RST_BYTE;
		end else if (wr_pol_low) begin
			pol_low_q <= wbyte; // RL18
		end
	end

	// High polarity byte, cleared in standby
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || standby_i) begin
			pol_high_q <= `PWOC_RST_BYTE;
		end else if (wr_pol_high) begin
			pol_high_q <= wbyte; // RL18
		end
	end

	// Port one direction, kept through standby
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			dir_one_q <= `PWOC_RST_BYTE;
		end else if (wr_dir_one) begin
			dir_one_q <= wbyte; // RL7
		end
	end

	// Port two direction, kept through standby
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			dir_two_q <= `PWOC_RST_BYTE;
		end else if (wr_dir_two) begin
			dir_two_q <= wbyte; // RL7
		end
	end

	// Port one level byte
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			lvl_one_q <= `PWOC_RST_BYTE;
		end else if (wr_lvl_one) begin
			lvl_one_q <= wbyte; // RL9
		end
	end

	// Port two level byte
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			lvl_two_q <= `PWOC_RST_BYTE;
		end else if (wr_lvl_two) begin
			lvl_two_q <= wbyte; // RL9
		end
	end

	// Shared control register
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			shared_serial_timer_control_q <= `PWOC_RST_BYTE; // RL10
		end else if (wr_shared_serial_timer_control) begin
			shared_serial_timer_control_q <= wbyte; // RL10
		end
	end

	// Duty values, cleared in standby
	always_ff @(posedge sys_clk_i) begin
		for (int n = 0; n < CHANNELS; n++) begin
			if (reset_i || standby_i) begin
				duty_q[n] <= `PWOC_RST_BYTE;
			end else if (wr_duty && (duty_idx == 4'(n))) begin
				duty_q[n] <= wbyte;
			end
		end
	end

	// Half-rate phase, toggles every cycle
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			half_q <= 1'b0;
		end else begin
			half_q <= !half_q;
		end
	end

	// Shared counter, holds while the gate is off
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			count_q <= 8'h00;
		end else if (tick) begin
			count_q <= count_q + 8'h01; // RL13 RL14 RL19
		end
	end

	// Pin level drivers
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pin_q <= '0;
		end else begin
			pin_q <= pin_d;
		end
	end

	// Pin enable drivers, released after reset
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			oe_n_q <= '1;
		end else begin
			oe_n_q <= oe_n_d;
		end
	end

	assign wb_dat_o = rdata_q;
	assign wb_ack_o = ack_q;
	assign pulse_out_pin_o = pin_q;
	assign pulse_out_pin_oe_n_o = oe_n_q;
	assign byte_timer_clock_sel_o = shared_serial_timer_control_q[`PWOC_MSB_BYTE_TMR:`PWOC_LSB_BYTE_TMR]; // RL15
	assign interconnect_output_gate_o = shared_serial_timer_control_q[`PWOC_BIT_SYNC_GATE]; // RL16
	assign two_wire_ctrl_o = shared_serial_timer_control_q[`PWOC_MSB_TWO_WIRE:`PWOC_LSB_TWO_WIRE]; // RL16
	assign shared_up_counter_o = count_q;

endmodule

`default_nettype wire

// *** verif/pwoc_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the register bus, pins, side outputs and counter
module pwoc_chk #(
	parameter int CHANNELS = 16
) (
	input wire logic sys_clk_i, // Clock
	input wire logic reset_i, // Reset
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic [7:0] wb_adr_i, // Address
	input wire logic [3:0] wb_sel_i, // Byte selects
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Ack
	input wire logic [CHANNELS-1:0] pulse_out_pin_o, // Pins
	input wire logic [CHANNELS-1:0] pulse_out_pin_oe_n_o, // Enables
	input wire logic [1:0] byte_timer_clock_sel_o, // Byte timers
	input wire logic interconnect_output_gate_o, // Interconnect
	input wire logic [2:0] two_wire_ctrl_o, // Two-wire
	input wire logic [7:0] shared_up_counter_o // Counter
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	// Request taken by the slave
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire [5:0] side = {two_wire_ctrl_o, interconnect_output_gate_o, byte_timer_clock_sel_o};
	// Control byte reaches the side outputs
	property p_side;
		logic [7:0] d;
		(take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h18, d = wb_dat_i[7:0])
			|=> side == {d[7:4], d[1:0]};
	endproperty
	a_side_follow: assert property (p_side) else $error("side outputs");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
	a_ack_after_take: assert property (take |=> wb_ack_o) else $error("ack late");
	a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat idle");
	a_dir_reads_zero: assert property (take && !wb_we_i && (wb_adr_i == 8'h08 || wb_adr_i == 8'h0c)
		|=> wb_dat_o == 32'h0) else $error("dir read");
	a_count_step: assert property (!$stable(shared_up_counter_o) |->
		shared_up_counter_o == $past(shared_up_counter_o) + 8'h01) else $error("step");
	a_input_pin_low: assert property ((pulse_out_pin_o & pulse_out_pin_oe_n_o) == '0)
		else $error("input pin driven");
	a_reset_clear: assert property (disable iff (1'b0) reset_i |=> pulse_out_pin_oe_n_o == '1
		&& shared_up_counter_o == 8'h00 && !wb_ack_o && side == 6'h00) else $error("reset");
	c_write: cover property (take && wb_we_i);
	c_drive: cover property (pulse_out_pin_o != '0);
	c_count: cover property (!$stable(shared_up_counter_o));
endmodule
bind pwoc_top pwoc_chk #(.CHANNELS(CHANNELS)) u_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.pulse_out_pin_o(pulse_out_pin_o), .pulse_out_pin_oe_n_o(pulse_out_pin_oe_n_o),
	.byte_timer_clock_sel_o(byte_timer_clock_sel_o),
	.interconnect_output_gate_o(interconnect_output_gate_o),
	.two_wire_ctrl_o(two_wire_ctrl_o), .shared_up_counter_o(shared_up_counter_o));
`default_nettype wire

// *** verif/pwoc_load.sv ***
`timescale 1ns/1ps
`default_nettype none
// Board loads with pull-downs on the sixteen pulse pins
module pwoc_load (
	input wire logic [15:0] pin_i, // Pin level
	input wire logic [15:0] oe_n_i, // Low drives
	output logic [15:0] wire_o // Level on the board
);
	// A released pin falls to the pull-down level
	assign wire_o = pin_i & ~oe_n_i;
endmodule
`default_nettype wire

// *** verif/pulse_width_output_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module pulse_width_output_control_test;
	logic clk, rst, sb, cyc, stb, we, ack, ic;
	logic [7:0] adr, q, c0, dv, cnt;
	logic [31:0] wd, rd;
	logic [15:0] pin, oen, wl, dr, oe, lv, pl, hi;
	logic [1:0] bt;
	logic [2:0] tw;
	int failures = 0, checks = 0, cycles = 0, ch;
	pwoc_top u_dut (.sys_clk_i(clk), .reset_i(rst), .standby_i(sb), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.pulse_out_pin_o(pin), .pulse_out_pin_oe_n_o(oen), .byte_timer_clock_sel_o(bt),
		.interconnect_output_gate_o(ic), .two_wire_ctrl_o(tw), .shared_up_counter_o(cnt));
	pwoc_load u_load (.pin_i(pin), .oe_n_i(oen), .wire_o(wl));
	// Clock of 25 ns
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Cycle ceiling against hangs
	always @(posedge clk) begin
		cycles++;
		if (cycles > 8000) begin
			failures++;
			conclude();
		end
	end
	// One classic bus cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= {24'h000000, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rd[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Writes enables, directions, levels, control and polarity in offset order
	task automatic setup(input logic [71:0] v);
		for (int j = 0; j < 9; j++) wb(1'b1, 8'(4 * j), v[8*j +: 8]);
	endtask
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic conclude();
		if (failures == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Pin level in input, level and zero-duty waveform modes
	function automatic logic [15:0] lvl_exp(input logic [15:0] d, o, l, p);
		return (d & ~o & (l ^ p)) | (d & o & p);
	endfunction
	// High steps in one 256-step period
	function automatic logic [15:0] hi_exp(input logic [7:0] d, input logic p);
		logic [15:0] n;
		n = 16'(16 * d[7:4] + d[3:0]);
		return p ? 16'h0100 - n : n;
	endfunction
	initial begin
		rst = 1'b1;
		{sb, cyc, stb, we, adr, wd} = 44'h0;
		void'($urandom(32'hfc4c));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		// Offsets 0x00 to 0x24 read zero after reset, unmapped 0x28 too
		for (int i = 0; i < 11; i++) begin
			wb(1'b0, 8'(4 * i), 8'h00);
			cmp({8'h00, q}, 16'h0000);
		end
		// Control round trip with the gate off
		dv = 8'($urandom) & 8'hf3;
		wb(1'b1, 8'h18, dv);
		wb(1'b0, 8'h18, 8'h00);
		cmp({8'h00, q}, {8'h00, dv});
		cmp({10'h000, tw, ic, bt}, {10'h000, dv[7:4], dv[1:0]});
		// Random pin modes, polarity clear then random
		for (int k = 0; k < 2; k++) begin
			{dr, oe, lv, pl} = {$urandom, $urandom};
			if (k == 0) pl = 16'h0000;
			setup({pl, dv, lv, dr, oe});
			repeat (2) @(posedge clk);
			cmp(oen, ~dr);
			cmp(pin, lvl_exp(dr, oe, lv, pl));
		end
		wb(1'b0, 8'h0c, 8'h00);
		cmp({8'h00, q}, 16'h0000);
		// Counter gated off, then full rate, then half rate
		for (int k = 0; k < 3; k++) begin
			wb(1'b1, 8'h18, 8'(4 + 4 * k));
			@(posedge clk);
			c0 = cnt;
			repeat (300) @(posedge clk);
			cmp({8'h00, cnt}, {8'h00, c0 + 8'(k == 0 ? 0 : 300 >> (k - 1))});
		end
		// Duty over one period, corner values first
		for (int k = 0; k < 4; k++) begin
			ch = $urandom_range(15);
			dv = k == 0 ? 8'h00 : k == 1 ? 8'hff : 8'($urandom);
			pl = k[0] ? 16'hffff : 16'h0000;
			setup({pl, 8'h08, 16'h0000, 16'hffff, 16'hffff});
			wb(1'b1, 8'(8'h40 + 4 * ch), dv);
			repeat (3) @(posedge clk);
			hi = 16'h0000;
			repeat (256) begin
				@(posedge clk);
				hi = hi + 16'(wl[ch]);
			end
			cmp(hi, hi_exp(dv, pl[0]));
		end
		// Standby clears the enables
		sb <= 1'b1;
		@(posedge clk);
		sb <= 1'b0;
		wb(1'b0, 8'h04, 8'h00);
		cmp({8'h00, q}, 16'h0000);
		conclude();
	end
endmodule
`default_nettype wire
